/* File: rtl/drive_power_state_control_words.v */
// Control, state, error and velocity words of the drive power stage,
// reached by object dictionary index from the fieldbus protocol logic.
// Assumes every input is driven by logic on clk_in; none come from pins.
//
// Overview of operation
// - 16-bit command word, read/write, reset zero, steers the power states.
// - Command bit 0 high requests the switched-on state.
// - Command bit 1 high requests voltage to be enabled.
// - Command bit 2 low forces quick stop; high for normal running.
// - Command bit 3 high requests operation enabled, the drive running.
// - A rising edge of command bit 7 clears a pending fault when clearing is possible.
// - Command bit 8 halts motion in the five halt-capable modes only.
// - Command bits 4-6, 9 and state bits 12-13 are mode specific.
// - 16-bit read-only state word, reset zero, reports the power state.
// - State bit 8 is one while synchronised with the fieldbus.
// - State bit 9 always reads one once out of reset.
// - State bit 15 is one after setup succeeded and encoder index seen.
// - State bit 11 is set when an internal limit is exceeded.
// - Patterns 0,0000 not ready and 1,0000 switch-on disabled, bit 5 ignored.
// - Bits 6,5 at 0,1 with 0001, 0011, 0111: ready, switched on, enabled.
// - Quick stop 00,0111; bit 6 zero with 1111 reaction, 1000 fault.
// - Signed 16-bit velocity setpoint, read/write, reset 200.
// - Signed 16-bit read-only commanded velocity, reset zero.
// - 16-bit read-only last error code, reset zero.
// - Error code equals low 16 bits of the newest error history entry.
// - Setpoint outside min or max is clamped and sets state bit 11.
`timescale 1ns/1ps
`default_nettype none
`include "drive_word_defines.vh"

module drive_power_state_control_words (
  input wire clk_in,
  input wire rst_n_in,
  // Object dictionary access
  input wire [15:0] od_index_in,
  input wire od_read_in,
  input wire od_write_in,
  input wire [15:0] od_wdata_in,
  output reg [15:0] od_rdata_out,
  output reg od_ack_out,
  output reg od_error_out,
  // Drive status sources
  input wire sync_locked_in,
  input wire autosetup_ok_in,
  input wire index_seen_in,
  input wire warning_in,
  input wire goal_reached_in,
  input wire [1:0] mode_status_in,
  input wire fault_event_in,
  input wire fault_reaction_done_in,
  input wire fault_clearable_in,
  input wire [31:0] error_history_in,
  input wire [7:0] op_mode_in,
  input wire [31:0] velocity_min_in,
  input wire [31:0] velocity_max_in,
  // Results toward the drive
  output reg [2:0] power_state_out,
  output reg voltage_applied_out,
  output reg run_out,
  output reg halt_out,
  output reg [3:0] mode_specific_bits_out,
  output reg [15:0] velocity_commanded_out,
  output reg internal_limit_hit_out
);

  // ****************************************
  // Stored words
  // ****************************************
  reg [15:0] drive_command_word_q;
  reg [15:0] velocity_setpoint_q;
  reg [15:0] last_error_code_q;
  reg [15:0] drive_state_word_q;
  reg [15:0] velocity_commanded_now_q;
  reg [15:0] drive_state_word_d;
  reg [15:0] velocity_commanded_now_d;
  reg [15:0] rdata_d;
  reg hit_d;
  reg err_d;

  wire [2:0] fsm_state;
  wire [6:0] fsm_bits;
  wire [15:0] clamped_velocity;
  wire clamp_active;

  // ****************************************
  // Access decode
  // ****************************************
  wire wr_cmd = od_write_in && (od_index_in == `IDX_DRIVE_COMMAND_WORD);
  wire wr_vel = od_write_in && (od_index_in == `IDX_VELOCITY_SETPOINT);
  wire access = od_read_in | od_write_in;

  // Write takes priority when both strobes are seen together
  always @* begin
    rdata_d = 16'h0000;
    hit_d = 1'b1;
    case (od_index_in)
      `IDX_LAST_ERROR_CODE: rdata_d = last_error_code_q;
      `IDX_DRIVE_COMMAND_WORD: rdata_d = drive_command_word_q;
      `IDX_DRIVE_STATE_WORD: rdata_d = drive_state_word_q;
      `IDX_VELOCITY_SETPOINT: rdata_d = velocity_setpoint_q;
      `IDX_VELOCITY_COMMANDED_NOW: rdata_d = velocity_commanded_now_q;
      default: hit_d = 1'b0;
    endcase
  end

  always @* begin
    err_d = 1'b0;
    if (od_write_in) begin
      // Read-only words refuse a write without changing
      err_d = ~(wr_cmd | wr_vel);
    end else if (od_read_in) begin
      err_d = ~hit_d;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      od_rdata_out <= 16'h0000;
      od_ack_out <= 1'b0;
      od_error_out <= 1'b0;
    end else begin
      od_ack_out <= access;
      od_error_out <= access & err_d;
      if (od_read_in && !od_write_in && hit_d) begin
        od_rdata_out <= rdata_d;
      end else begin
        od_rdata_out <= 16'h0000;
      end
    end
  end

  // ****************************************
  // Writable words
  // ****************************************
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      drive_command_word_q <= `RST_DRIVE_COMMAND_WORD;
      velocity_setpoint_q <= `RST_VELOCITY_SETPOINT;
    end else begin
      if (wr_cmd) begin
        drive_command_word_q <= od_wdata_in;
      end
      if (wr_vel) begin
        velocity_setpoint_q <= od_wdata_in;
      end
    end
  end

  // ****************************************
  // Power state machine
  // ****************************************
  power_state_machine u_fsm (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .cmd_in(drive_command_word_q),
    .fault_event_in(fault_event_in),
    .reaction_done_in(fault_reaction_done_in),
    .clearable_in(fault_clearable_in),
    .state_out(fsm_state),
    .state_bits_out(fsm_bits)
  );

  // ****************************************
  // Setpoint limiting
  // ****************************************
  velocity_clamp #(
    .W(16)
  ) u_clamp (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .target_in(velocity_setpoint_q),
    .min_in(velocity_min_in),
    .max_in(velocity_max_in),
    .clamped_out(clamped_velocity),
    .limit_out(clamp_active)
  );

  // ****************************************
  // Halt qualification
  // ****************************************
  reg halt_mode;
  always @* begin
    case (op_mode_in)
      `MODE_PROFILE_POSITION: halt_mode = 1'b1;
      `MODE_VELOCITY: halt_mode = 1'b1;
      `MODE_PROFILE_VELOCITY: halt_mode = 1'b1;
      `MODE_PROFILE_TORQUE: halt_mode = 1'b1;
      `MODE_INTERPOLATED_POSITION: halt_mode = 1'b1;
      default: halt_mode = 1'b0;
    endcase
  end

  wire halt_now = drive_command_word_q[`CW_HALT] & halt_mode;
  // Running state code of the state machine, read from its bit pattern
  wire running = (fsm_bits == 7'h37);

  // ****************************************
  // State word and commanded velocity
  // ****************************************
  always @* begin
    drive_state_word_d = 16'h0000;
    drive_state_word_d[6:0] = fsm_bits;
    drive_state_word_d[`SW_WARNING] = warning_in;
    drive_state_word_d[`SW_SYNC] = sync_locked_in;
    drive_state_word_d[`SW_HOST_CONTROLLED] = 1'b1;
    drive_state_word_d[`SW_GOAL_REACHED] = goal_reached_in;
    drive_state_word_d[`SW_INTERNAL_LIMIT_HIT] = clamp_active;
    drive_state_word_d[`SW_MODE_LO+1:`SW_MODE_LO] = mode_status_in;
    // Both conditions must hold; either alone is not enough
    drive_state_word_d[`SW_CLOSED_LOOP_READY] =
      autosetup_ok_in & index_seen_in;
  end

  // Ramps live outside; the demand steps straight to the limited setpoint
  always @* begin
    if (running && !halt_now) begin
      velocity_commanded_now_d = clamped_velocity;
    end else begin
      velocity_commanded_now_d = 16'h0000;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      drive_state_word_q <= `RST_DRIVE_STATE_WORD;
      velocity_commanded_now_q <= `RST_VELOCITY_COMMANDED_NOW;
      last_error_code_q <= `RST_LAST_ERROR_CODE;
    end else begin
      drive_state_word_q <= drive_state_word_d;
      velocity_commanded_now_q <= velocity_commanded_now_d;
      last_error_code_q <= error_history_in[15:0];
    end
  end

  // ****************************************
  // Drive-side outputs
  // ****************************************
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      power_state_out <= 3'h0;
      voltage_applied_out <= 1'b0;
      run_out <= 1'b0;
      halt_out <= 1'b0;
      mode_specific_bits_out <= 4'h0;
      velocity_commanded_out <= 16'h0000;
      internal_limit_hit_out <= 1'b0;
    end else begin
      power_state_out <= fsm_state;
      voltage_applied_out <= fsm_bits[4];
      run_out <= running;
      halt_out <= halt_now;
      mode_specific_bits_out <= {drive_command_word_q[`CW_MODE_BIT9],
                                 drive_command_word_q[6:4]};
      velocity_commanded_out <= velocity_commanded_now_d;
      internal_limit_hit_out <= clamp_active;
    end
  end

endmodule // drive_power_state_control_words

`default_nettype wire

/* File: rtl/drive_word_defines.vh */
// Constants for the drive control, status and velocity word set.
// Assumes a single clock domain; included by bare name in the modules that use its names.
`ifndef DRIVE_WORD_DEFINES_VH
`define DRIVE_WORD_DEFINES_VH

// ****************************************
// Object dictionary indices
// ****************************************
`define IDX_LAST_ERROR_CODE 16'h603f
`define IDX_DRIVE_COMMAND_WORD 16'h6040
`define IDX_DRIVE_STATE_WORD 16'h6041
`define IDX_VELOCITY_SETPOINT 16'h6042
`define IDX_VELOCITY_COMMANDED_NOW 16'h6043

// ****************************************
// Reset values
// ****************************************
`define RST_LAST_ERROR_CODE 16'h0000
`define RST_DRIVE_COMMAND_WORD 16'h0000
`define RST_DRIVE_STATE_WORD 16'h0000
`define RST_VELOCITY_SETPOINT 16'h00c8
`define RST_VELOCITY_COMMANDED_NOW 16'h0000

// ****************************************
// Command word bit positions
// ****************************************
`define CW_SWITCH_ON 0
`define CW_VOLTAGE_REQUEST 1
`define CW_QUICK_STOP_N 2
`define CW_RUN_REQUEST 3
`define CW_ERROR_CLEAR_REQUEST 7
`define CW_HALT 8
`define CW_MODE_BIT9 9

// ****************************************
// State word bit positions
// ****************************************
`define SW_WARNING 7
`define SW_SYNC 8
`define SW_HOST_CONTROLLED 9
`define SW_GOAL_REACHED 10
`define SW_INTERNAL_LIMIT_HIT 11
`define SW_MODE_LO 12
`define SW_CLOSED_LOOP_READY 15

// ****************************************
// Operating mode codes where halt acts
// ****************************************
`define MODE_PROFILE_POSITION 8'h01
`define MODE_VELOCITY 8'h02
`define MODE_PROFILE_VELOCITY 8'h03
`define MODE_PROFILE_TORQUE 8'h04
`define MODE_INTERPOLATED_POSITION 8'h07

`endif

/* File: rtl/velocity_clamp.v */
// Clamps a signed velocity setpoint by magnitude to a min/max amount.
// Assumes min and max come from configuration logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module velocity_clamp #(
  parameter W = 16
) (
  input wire clk_in,
  input wire rst_n_in,
  input wire [W-1:0] target_in,
  input wire [31:0] min_in,
  input wire [31:0] max_in,
  output reg [W-1:0] clamped_out,
  output reg limit_out
);
  wire neg = target_in[W-1];
  wire [W-1:0] mag = neg ? (~target_in + {{(W-1){1'b0}}, 1'b1}) : target_in;
  wire [31:0] mag32 = {{(32-W){1'b0}}, mag};
  wire below = mag32 < min_in;
  wire above = mag32 > max_in;
  // Largest magnitude the signed word can hold
  wire [31:0] cap = {{(33-W){1'b0}}, {(W-1){1'b1}}};
  reg [31:0] lim;
  always @* begin
    lim = mag32;
    if (above) lim = max_in;
    // Minimum wins when limits are misconfigured
    if (below) lim = min_in;
  end
  wire [31:0] sat = (lim > cap) ? cap : lim;
  wire [W-1:0] sat_w = sat[W-1:0];
  wire [W-1:0] res = neg ? (~sat_w + {{(W-1){1'b0}}, 1'b1}) : sat_w;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      clamped_out <= {W{1'b0}};
      limit_out <= 1'b0;
    end else begin
      clamped_out <= res;
      limit_out <= below | above;
    end
  end
endmodule // velocity_clamp

`default_nettype wire

/* File: rtl/power_state_machine.v */
// Power state machine driven by the command word bits.
// Assumes fault events and reaction-done come from drive logic, same clock.
`timescale 1ns/1ps
`default_nettype none
`include "drive_word_defines.vh"

module power_state_machine (
  input wire clk_in,
  input wire rst_n_in,
  input wire [15:0] cmd_in,
  input wire fault_event_in,
  input wire reaction_done_in,
  input wire clearable_in,
  output reg [2:0] state_out,
  output reg [6:0] state_bits_out
);
  localparam ST_NOT_READY = 3'h0;
  localparam ST_SW_DISABLED = 3'h1;
  localparam ST_READY = 3'h2;
  localparam ST_SWITCHED_ON = 3'h3;
  localparam ST_RUNNING = 3'h4;
  localparam ST_QUICK_STOP = 3'h5;
  localparam ST_FAULT_REACT = 3'h6;
  localparam ST_FAULT = 3'h7;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg clear_prev_q;
  wire sw_on = cmd_in[`CW_SWITCH_ON];
  wire volt = cmd_in[`CW_VOLTAGE_REQUEST];
  wire qs_n = cmd_in[`CW_QUICK_STOP_N];
  wire run = cmd_in[`CW_RUN_REQUEST];
  wire shutdown = volt & qs_n & ~sw_on;
  wire switch_on = volt & qs_n & sw_on & ~run;
  wire enable_op = volt & qs_n & sw_on & run;
  wire quick = volt & ~qs_n;
  // Edge, so a held clear request cannot mask a later fault
  wire clear_edge = cmd_in[`CW_ERROR_CLEAR_REQUEST] & ~clear_prev_q;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_NOT_READY: state_d = ST_SW_DISABLED;
      ST_SW_DISABLED: if (shutdown) state_d = ST_READY;
      ST_READY: begin
        if (switch_on | enable_op) state_d = ST_SWITCHED_ON;
        else if (~volt | quick) state_d = ST_SW_DISABLED;
      end
      ST_SWITCHED_ON: begin
        if (enable_op) state_d = ST_RUNNING;
        else if (shutdown) state_d = ST_READY;
        else if (~volt | quick) state_d = ST_SW_DISABLED;
      end
      ST_RUNNING: begin
        if (switch_on) state_d = ST_SWITCHED_ON;
        else if (shutdown) state_d = ST_READY;
        else if (~volt) state_d = ST_SW_DISABLED;
        else if (quick) state_d = ST_QUICK_STOP;
      end
      ST_QUICK_STOP: begin
        if (~volt) state_d = ST_SW_DISABLED;
        else if (enable_op) state_d = ST_RUNNING;
      end
      ST_FAULT_REACT: if (reaction_done_in) state_d = ST_FAULT;
      ST_FAULT: if (clear_edge & clearable_in) state_d = ST_SW_DISABLED;
      default: state_d = ST_NOT_READY;
    endcase
    if (fault_event_in && state_q != ST_FAULT_REACT && state_q != ST_FAULT) begin
      state_d = ST_FAULT_REACT;
    end
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_NOT_READY;
      clear_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      clear_prev_q <= cmd_in[`CW_ERROR_CLEAR_REQUEST];
    end
  end

  // Bits 6..0 of the state word; bit 4 marks voltage applied
  always @* begin
    state_out = state_q;
    case (state_q)
      ST_NOT_READY: state_bits_out = 7'h00;
      ST_SW_DISABLED: state_bits_out = 7'h60;
      ST_READY: state_bits_out = 7'h21;
      ST_SWITCHED_ON: state_bits_out = 7'h33;
      ST_RUNNING: state_bits_out = 7'h37;
      ST_QUICK_STOP: state_bits_out = 7'h17;
      ST_FAULT_REACT: state_bits_out = 7'h1f;
      ST_FAULT: state_bits_out = 7'h08;
      default: state_bits_out = 7'h00;
    endcase
  end
endmodule // power_state_machine

`default_nettype wire

/* File: dv/drive_word_checker.sv */
// Assertions on the dictionary access port of the drive word set.
// Assumes it is bound to the top design module.
`timescale 1ns/1ps
`default_nettype none
`include "drive_word_defines.vh"
module drive_word_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [15:0] od_index_in,
  input wire logic od_read_in,
  input wire logic od_write_in,
  input wire logic [15:0] od_wdata_in,
  input wire logic [15:0] od_rdata_out,
  input wire logic od_ack_out,
  input wire logic od_error_out,
  input wire logic sync_locked_in,
  input wire logic autosetup_ok_in,
  input wire logic index_seen_in
);
  // ****
  // Helpers
  // ****
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [1:0] up_q;
  wire logic stb = od_read_in | od_write_in;
  wire logic hit = od_index_in >= 16'h603f && od_index_in <= 16'h6043;
  wire logic ro = od_index_in == 16'h603f || od_index_in == 16'h6041 || od_index_in == 16'h6043;
  // State word needs three settled cycles after reset
  wire logic rd_sw = od_read_in && !od_write_in && od_index_in == 16'h6041 && up_q == 2'h3;
  always @(posedge clk_in) begin
    if (!rst_n_in) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  sequence s_cmd_write;
    od_write_in && od_index_in == `IDX_DRIVE_COMMAND_WORD;
  endsequence
  sequence s_cmd_readback;
    s_cmd_write ##1 !od_write_in
      ##1 (od_read_in && !od_write_in && od_index_in == `IDX_DRIVE_COMMAND_WORD);
  endsequence
  // ****
  // Properties
  // ****
  chk_strobe_acked: assert property (stb |=> od_ack_out)
    else $error("strobe not acknowledged");
  chk_no_stray_ack: assert property (!stb |=>
    !od_ack_out && !od_error_out && od_rdata_out == 0)
    else $error("answer without strobe");
  chk_unmapped_err: assert property (stb && !hit |=>
    od_error_out && od_rdata_out == 0)
    else $error("unmapped index not refused");
  chk_ro_refused: assert property (od_write_in && ro |=> od_error_out)
    else $error("write to read-only word accepted");
  chk_rw_accepted: assert property (od_write_in && hit && !ro
    |=> !od_error_out)
    else $error("write to writable word refused");
  chk_cmd_readback: assert property (s_cmd_readback |=>
    od_rdata_out == $past(od_wdata_in, 3))
    else $error("command word readback differs");
  chk_remote_one: assert property (rd_sw |=> od_rdata_out[9])
    else $error("remote bit low");
  chk_sync_bit: assert property (rd_sw && $stable(sync_locked_in) |=>
    od_rdata_out[8] == $past(sync_locked_in))
    else $error("sync bit wrong");
  chk_closed_loop: assert property (rd_sw
    && $stable(autosetup_ok_in && index_seen_in)
    |=> od_rdata_out[15] == $past(autosetup_ok_in && index_seen_in))
    else $error("closed loop bit wrong");
endmodule // drive_word_checker
bind drive_power_state_control_words drive_word_checker i_drive_word_checker (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .od_index_in(od_index_in),
  .od_read_in(od_read_in), .od_write_in(od_write_in), .od_wdata_in(od_wdata_in),
  .od_rdata_out(od_rdata_out), .od_ack_out(od_ack_out), .od_error_out(od_error_out),
  .sync_locked_in(sync_locked_in), .autosetup_ok_in(autosetup_ok_in),
  .index_seen_in(index_seen_in));
`default_nettype wire

/* File: dv/od_master_model.sv */
// Fieldbus master model issuing dictionary accesses.
// Assumes the design acknowledges one cycle after each strobe.
`timescale 1ns/1ps
`default_nettype none
module od_master_model (
  input wire logic clk_in,
  input wire logic [15:0] od_rdata_out,
  input wire logic od_ack_out,
  input wire logic od_error_out,
  output logic [15:0] od_index_in,
  output logic od_read_in,
  output logic od_write_in,
  output logic [15:0] od_wdata_in
);
  initial begin
    od_index_in = 16'h0000;
    od_read_in = 1'b0;
    od_write_in = 1'b0;
    od_wdata_in = 16'h0000;
  end
  // One-cycle strobe; strobes then drop low, index and data lines show the inverse, not stale values
  task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
      output logic [15:0] rd, output logic ack, output logic err);
    @(posedge clk_in);
    #1;
    od_index_in = idx;
    od_wdata_in = wd;
    od_read_in = !wr;
    od_write_in = wr;
    @(posedge clk_in);
    #1;
    rd = od_rdata_out;
    ack = od_ack_out;
    err = od_error_out;
    od_read_in = 1'b0;
    od_write_in = 1'b0;
    od_index_in = ~idx;
    od_wdata_in = ~wd;
  endtask
endmodule // od_master_model
`default_nettype wire

/* File: dv/testbench.sv */
// Self-checking bench for the drive word set.
// Assumes the design, the master model and the checker are compiled before.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  // ****
  // Signals
  // ****
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sync_locked_in = 1'b0, autosetup_ok_in = 1'b0, index_seen_in = 1'b0;
  logic warning_in = 1'b0, goal_reached_in = 1'b0, fault_event_in = 1'b0;
  logic fault_reaction_done_in = 1'b0, fault_clearable_in = 1'b0;
  logic [1:0] mode_status_in = 2'h0;
  logic [31:0] error_history_in = 32'h0, velocity_min_in = 32'h0, velocity_max_in = 32'h4e20;
  logic [7:0] op_mode_in = 8'h02;
  wire logic [15:0] od_index_in, od_wdata_in, od_rdata_out, velocity_commanded_out;
  wire logic od_read_in, od_write_in, od_ack_out, od_error_out;
  wire logic [2:0] power_state_out;
  wire logic voltage_applied_out, run_out, halt_out, internal_limit_hit_out;
  wire logic [3:0] mode_specific_bits_out;
  int err_count = 0;
  int comparisons = 0;
  logic [15:0] dem;
  typedef struct packed {logic wr; logic [15:0] idx, wd, rd; logic err;} acc_t;
  typedef struct packed {logic [15:0] cmd; logic [7:0] mode; logic [6:0] low; logic [2:0] st;
    logic halt;} st_t;
  typedef struct packed {logic [31:0] lo, hi; logic [15:0] sp, dem; logic lim;} cl_t;
  acc_t acc_rows [11] = '{
    '{1'b0, 16'h603f, 16'h0, 16'h0000, 1'b0}, '{1'b0, 16'h6040, 16'h0, 16'h0000, 1'b0},
    '{1'b0, 16'h6041, 16'h0, 16'h0260, 1'b0}, '{1'b0, 16'h6042, 16'h0, 16'h00c8, 1'b0},
    '{1'b0, 16'h6043, 16'h0, 16'h0000, 1'b0}, '{1'b1, 16'h6041, 16'hffff, 16'h0, 1'b1},
    '{1'b1, 16'h603f, 16'h1111, 16'h0, 1'b1}, '{1'b1, 16'h6043, 16'h2222, 16'h0, 1'b1},
    '{1'b0, 16'h6044, 16'h0, 16'h0000, 1'b1}, '{1'b1, 16'h6042, 16'h0123, 16'h0, 1'b0},
    '{1'b0, 16'h6042, 16'h0, 16'h0123, 1'b0}};
  st_t st_rows [7] = '{
    '{16'h0006, 8'h02, 7'h21, 3'h2, 1'b0}, '{16'h0007, 8'h02, 7'h33, 3'h3, 1'b0},
    '{16'h000f, 8'h02, 7'h37, 3'h4, 1'b0}, '{16'h010f, 8'h05, 7'h37, 3'h4, 1'b0},
    '{16'h010f, 8'h02, 7'h37, 3'h4, 1'b1}, '{16'h000b, 8'h02, 7'h17, 3'h5, 1'b0},
    '{16'h000f, 8'h02, 7'h37, 3'h4, 1'b0}};
  cl_t cl_rows [4] = '{
    '{32'd0, 32'd100, 16'h00c8, 16'h0064, 1'b1}, '{32'd0, 32'd100, 16'hfed4, 16'hff9c, 1'b1},
    '{32'd50, 32'd100, 16'h000a, 16'h0032, 1'b1}, '{32'd0, 32'h4e20, 16'h0123, 16'h0123, 1'b0}};
  // ****
  // Instances
  // ****
  drive_power_state_control_words i_drive_power_state_control_words (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .od_index_in(od_index_in), .od_read_in(od_read_in),
    .od_write_in(od_write_in), .od_wdata_in(od_wdata_in), .od_rdata_out(od_rdata_out),
    .od_ack_out(od_ack_out), .od_error_out(od_error_out), .sync_locked_in(sync_locked_in),
    .autosetup_ok_in(autosetup_ok_in), .index_seen_in(index_seen_in), .warning_in(warning_in),
    .goal_reached_in(goal_reached_in), .mode_status_in(mode_status_in),
    .fault_event_in(fault_event_in), .fault_reaction_done_in(fault_reaction_done_in),
    .fault_clearable_in(fault_clearable_in), .error_history_in(error_history_in),
    .op_mode_in(op_mode_in), .velocity_min_in(velocity_min_in),
    .velocity_max_in(velocity_max_in), .power_state_out(power_state_out),
    .voltage_applied_out(voltage_applied_out), .run_out(run_out), .halt_out(halt_out),
    .mode_specific_bits_out(mode_specific_bits_out),
    .velocity_commanded_out(velocity_commanded_out),
    .internal_limit_hit_out(internal_limit_hit_out));
  od_master_model i_od_master_model (.clk_in(clk_in), .od_rdata_out(od_rdata_out),
    .od_ack_out(od_ack_out), .od_error_out(od_error_out), .od_index_in(od_index_in),
    .od_read_in(od_read_in), .od_write_in(od_write_in), .od_wdata_in(od_wdata_in));
  always #5 clk_in = ~clk_in;
  // ****
  // Tasks
  // ****
  task automatic acc(input logic wr, input logic [15:0] idx, wd, msk, exp, input logic e);
    logic [15:0] rd;
    logic ack, err;
    i_od_master_model.access(wr, idx, wd, rd, ack, err);
    `CHECK(ack, 1'b1)
    `CHECK(err, e)
    `CHECK(rd & msk, exp)
  endtask
  // State word follows two edges after the command is stored
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic check_state(input logic [6:0] low, input logic [2:0] st);
    acc(1'b0, 16'h6041, 16'h0, 16'h007f, {9'h0, low}, 1'b0);
    `CHECK(power_state_out, st)
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100us;
    err_count++;
    close_out();
  end
  // ****
  // Tests
  // ****
  initial begin
    repeat (2) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    foreach (acc_rows[i]) begin
      acc_t r;
      r = acc_rows[i];
      acc(r.wr, r.idx, r.wd, 16'hffff, r.rd, r.err);
    end
    $display("test register table done");
    foreach (st_rows[i]) begin
      op_mode_in = st_rows[i].mode;
      acc(1'b1, 16'h6040, st_rows[i].cmd, 16'h0, 16'h0, 1'b0);
      settle();
      check_state(st_rows[i].low, st_rows[i].st);
      `CHECK(halt_out, st_rows[i].halt)
      `CHECK(run_out, st_rows[i].st == 3'h4)
      `CHECK(voltage_applied_out, st_rows[i].low[4])
      // Demand is only nonzero while running and not halted
      dem = (st_rows[i].st == 3'h4 && !st_rows[i].halt) ? 16'h0123 : 16'h0000;
      acc(1'b0, 16'h6043, 16'h0, 16'hffff, dem, 1'b0);
    end
    $display("test power states done");
    foreach (cl_rows[i]) begin
      velocity_min_in = cl_rows[i].lo;
      velocity_max_in = cl_rows[i].hi;
      acc(1'b1, 16'h6042, cl_rows[i].sp, 16'h0, 16'h0, 1'b0);
      settle();
      acc(1'b0, 16'h6043, 16'h0, 16'hffff, cl_rows[i].dem, 1'b0);
      `CHECK(velocity_commanded_out, cl_rows[i].dem)
      `CHECK(internal_limit_hit_out, cl_rows[i].lim)
      acc(1'b0, 16'h6041, 16'h0, 16'h0800, {4'h0, cl_rows[i].lim, 11'h0}, 1'b0);
    end
    $display("test clamp done");
    error_history_in = 32'h1234abcd;
    fault_event_in = 1'b1;
    @(posedge clk_in);
    #1 fault_event_in = 1'b0;
    settle();
    check_state(7'h1f, 3'h6);
    fault_reaction_done_in = 1'b1;
    settle();
    check_state(7'h08, 3'h7);
    acc(1'b0, 16'h603f, 16'h0, 16'hffff, 16'habcd, 1'b0);
    acc(1'b1, 16'h6040, 16'h0080, 16'h0, 16'h0, 1'b0);
    settle();
    check_state(7'h08, 3'h7);
    acc(1'b1, 16'h6040, 16'h0000, 16'h0, 16'h0, 1'b0);
    fault_clearable_in = 1'b1;
    acc(1'b1, 16'h6040, 16'h0080, 16'h0, 16'h0, 1'b0);
    settle();
    check_state(7'h60, 3'h1);
    fault_reaction_done_in = 1'b0;
    $display("test fault done");
    {sync_locked_in, autosetup_ok_in, warning_in, goal_reached_in} = 4'hf;
    mode_status_in = 2'h3;
    settle();
    acc(1'b0, 16'h6041, 16'h0, 16'hffff, 16'h37e0, 1'b0);
    index_seen_in = 1'b1;
    settle();
    acc(1'b0, 16'h6041, 16'h0, 16'hffff, 16'hb7e0, 1'b0);
    acc(1'b1, 16'h6040, 16'h0270, 16'h0, 16'h0, 1'b0);
    acc(1'b0, 16'h6040, 16'h0, 16'hffff, 16'h0270, 1'b0);
    settle();
    `CHECK(mode_specific_bits_out, 4'hf)
    $display("test status bits done");
    {sync_locked_in, autosetup_ok_in, warning_in, goal_reached_in, index_seen_in} = 5'h0;
    mode_status_in = 2'h0;
    error_history_in = 32'h0;
    rst_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    `CHECK(power_state_out, 3'h0)
    `CHECK(od_ack_out, 1'b0)
    rst_n_in = 1'b1;
    for (int i = 0; i < 5; i++) begin
      acc_t r;
      r = acc_rows[i];
      acc(r.wr, r.idx, r.wd, 16'hffff, r.rd, r.err);
    end
    $display("test second reset done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
